// *** osd_pkg.sv ***
// Oscillator select and divider: shared constants and types.
// Assumes a single 125 MHz clock and a plain strobe register port.
// Contract
// - Six-bit trim field is two's complement
// - Bits 14:12 report current source, read-only
// - Bits 10:8 select new source, eight codes
// - Switch request held until switch completes
// - Monitor config 00: freeze bit blocks switches
// - Monitor config 1x: switches never blocked
// - Control register writes need unlock first
// - Pin freeze needs unlock; one-shot keeps set
// - Lock bit high when locked or timer done
// - Lock bit cleared on switch, non-PLL mode
// - Bit 3 flags detected clock failure
// - Primary keeps running in sleep when set
// - Bit 1 enables the secondary oscillator
// - Source fields load from reset configuration
// - Interrupt clears ratio enable when recovering
// - Ratio field decodes 1:1 to 1:128, reset 011
// - Ratio applies only while enable is set
// - Divider source field decodes six sources
// - Postscaler divides PLL branch by 1,2,4,8
// - Force bit keeps PLL on, even asleep
package osd_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] OSD_OSC_CONTROL_REGISTER  = 12'h100;
    localparam logic [11:0] OSD_CLOCK_DIVIDER_REGISTER = 12'h102;
    localparam logic [11:0] OSD_TRIM_REGISTER         = 12'h106;
    localparam logic [11:0] OSD_UNLOCK_REGISTER       = 12'h110;
    localparam logic [15:0] OSD_UNLOCK_KEY1           = 16'h0046;
    localparam logic [15:0] OSD_UNLOCK_KEY2           = 16'h0057;
    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int OSD_CUR_LSB    = 12;
    localparam int OSD_NEW_LSB    = 8;
    localparam int OSD_FREEZE_BIT = 7;
    localparam int OSD_PIN_BIT    = 6;
    localparam int OSD_LOCK_BIT   = 5;
    localparam int OSD_FAIL_BIT   = 3;
    localparam int OSD_PKEEP_BIT  = 2;
    localparam int OSD_SEC_BIT    = 1;
    localparam int OSD_SW_BIT     = 0;
    // ------------------------------------------------------------
    // Divider register fields
    // ------------------------------------------------------------
    localparam int OSD_ROI_BIT    = 15;
    localparam int OSD_RATIO_LSB  = 12;
    localparam int OSD_RATEN_BIT  = 11;
    localparam int OSD_DSRC_LSB   = 8;
    localparam int OSD_POST_LSB   = 6;
    localparam int OSD_PLLF_BIT   = 5;
    localparam logic [2:0] OSD_RATIO_RESET = 3'h3;
    localparam logic [1:0] OSD_POST_RESET  = 2'h0;
    localparam logic       OSD_PLLF_RESET  = 1'b1;
    localparam logic [2:0] OSD_DSRC_RESET  = 3'h0;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int OSD_CLK_MHZ      = 125;
    localparam int OSD_SWITCH_NS    = 64;
    localparam int OSD_SWITCH_CYC   = (OSD_SWITCH_NS * OSD_CLK_MHZ + 999) / 1000;
    localparam int OSD_PLL_START_NS = 2000;
    localparam int OSD_PLL_START_CYC = (OSD_PLL_START_NS * OSD_CLK_MHZ + 999) / 1000;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OSD_SRC_FAST_RC        = 3'b000,
        OSD_SRC_FAST_RC_PLL    = 3'b001,
        OSD_SRC_PRIMARY        = 3'b010,
        OSD_SRC_PRIMARY_PLL    = 3'b011,
        OSD_SRC_SECONDARY      = 3'b100,
        OSD_SRC_LOW_POWER_RC   = 3'b101,
        OSD_SRC_RESERVED       = 3'b110,
        OSD_SRC_DIVIDED        = 3'b111
    } osd_src_t;
    typedef enum logic [1:0] {
        OSD_IDLE   = 2'b00,
        OSD_SWITCH = 2'b01
    } osd_state_t;
endpackage

// *** osd_pll_status.sv ***
// PLL lock tracking: start-up timer and lock status.
// Assumes the lock input is already synchronised by the caller.
`timescale 1ns/1ps
module osd_pll_status
    import osd_pkg::*;
#(
    parameter int START_CYC = OSD_PLL_START_CYC
)
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic pll_run,
    input  wire logic restart,
    input  wire logic pll_locked,
    output logic      lock_status
);
    typedef struct packed {
        logic [15:0] count;
        logic        done;
    } osd_pll_s_t;
    osd_pll_s_t s, next_s;

    always_comb
    begin
        next_s = s;
        if (!pll_run || restart)
        begin
            next_s.count = 16'h0000;
            next_s.done  = 1'b0;
        end
        else if (s.count != 16'(START_CYC))
            next_s.count = s.count + 16'h0001;
        else
            next_s.done = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            s <= '0;
        else
            s <= next_s;
    end

    // Locked or timer expired, never while off or restarting
    assign lock_status = pll_run & ~restart & (s.done | pll_locked);
endmodule

// *** osd_ratio_div.sv ***
// Peripheral clock ratio: one-cycle enable pulse every 2^ratio cycles.
// Assumes ratio fields come from the register file on the same clock.
`timescale 1ns/1ps
module osd_ratio_div
    import osd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       enable,
    input  wire logic [2:0] ratio,
    output logic            tick
);
    typedef struct packed {
        logic [6:0] count;
        logic       tick;
    } osd_rdiv_s_t;
    osd_rdiv_s_t s, next_s;
    logic [6:0] limit;

    always_comb
    begin
        limit  = enable ? 7'((8'h01 << ratio) - 8'h01) : 7'h00;
        next_s = s;
        if (s.count >= limit)
        begin
            next_s.count = 7'h00;
            next_s.tick  = 1'b1;
        end
        else
        begin
            next_s.count = s.count + 7'h01;
            next_s.tick  = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            s <= '0;
        else
            s <= next_s;
    end

    assign tick = s.tick;
endmodule

// *** osd_top.sv ***
// Oscillator source selection, switch sequencing and divider control.
// Assumes pins other than CLOCK_FAIL, PLL_LOCKED and IRQ are synchronous; bus is same clock.
`timescale 1ns/1ps
module osd_top
    import osd_pkg::*;
#(
    parameter int SWITCH_CYC = OSD_SWITCH_CYC,
    parameter int START_CYC  = OSD_PLL_START_CYC
)
(
    input  wire logic        CLK,
    input  wire logic        SRST,
    input  wire logic [11:0] ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    input  wire logic [2:0]  RESET_SOURCE_CONFIG,
    input  wire logic [1:0]  FAILSAFE_CONFIG,
    input  wire logic        PIN_LOCK_ONE_SHOT,
    input  wire logic        CLOCK_FAIL,
    input  wire logic        PLL_LOCKED,
    input  wire logic        IRQ,
    input  wire logic        SLEEP,
    output logic      [2:0]  ACTIVE_SOURCE,
    output logic             PRIMARY_RUN,
    output logic             SECONDARY_RUN,
    output logic             PLL_RUN,
    output logic      [3:0]  PLL_POST_DIV,
    output logic      [2:0]  DIVIDER_SOURCE,
    output logic      [5:0]  RC_TRIM,
    output logic             PIN_REMAP_FREEZE,
    output logic             PERIPH_TICK
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        osd_state_t  state;
        logic [7:0]  count;
        logic        loaded;
        logic        unlock1;
        logic        unlocked;
        logic [2:0]  current_source_sel;
        logic [2:0]  new_source_sel;
        logic        selection_freeze;
        logic        pin_remap_freeze;
        logic        clock_fail_flag;
        logic        primary_sleep_keep;
        logic        secondary_osc_enable;
        logic        switch_request;
        logic        recover_on_irq;
        logic [2:0]  ratio_sel;
        logic        ratio_reduce_enable;
        logic [2:0]  divider_source_sel;
        logic [1:0]  pll_postscale_sel;
        logic        pll_force_on;
        logic [5:0]  rc_trim_value;
        logic [15:0] rdata;
        logic        primary_run;
        logic        secondary_run;
        logic        pll_run;
        logic [3:0]  post_div;
        logic [2:0]  sync_fail1;
        logic [2:0]  sync_fail2;
    } osd_state_s_t;
    osd_state_s_t s, next_s;

    logic       lock_status;
    logic       restart;
    logic       periph_tick;
    logic       fail_s;
    logic       pll_lock_s;
    logic       irq_s;
    logic [2:0] sync_in;

    // Decode used for both the lock bit readback and run requests
    function automatic logic uses_pll(input logic [2:0] src);
        return (src == OSD_SRC_FAST_RC_PLL) || (src == OSD_SRC_PRIMARY_PLL);
    endfunction

    assign sync_in    = {CLOCK_FAIL, PLL_LOCKED, IRQ};
    assign fail_s     = s.sync_fail2[2];
    assign pll_lock_s = s.sync_fail2[1];
    assign irq_s      = s.sync_fail2[0];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic       wr_ctrl;
    logic       wr_div;
    logic       sel_locked;
    logic [1:0] pshift;

    always_comb
    begin
        next_s = s;
        restart = 1'b0;
        next_s.sync_fail1 = sync_in;
        next_s.sync_fail2 = s.sync_fail1;
        // Lock only holds with the monitor enabled
        sel_locked = (FAILSAFE_CONFIG == 2'b00) && s.selection_freeze;
        wr_ctrl = WR && (ADDR == OSD_OSC_CONTROL_REGISTER) && s.unlocked;
        wr_div  = WR && (ADDR == OSD_CLOCK_DIVIDER_REGISTER);

        // Strap capture after the reset is released
        if (!s.loaded)
        begin
            next_s.loaded             = 1'b1;
            next_s.current_source_sel = RESET_SOURCE_CONFIG;
            next_s.new_source_sel     = RESET_SOURCE_CONFIG;
        end

        // Two-write key opens one control register write
        if (WR && ADDR == OSD_UNLOCK_REGISTER)
        begin
            next_s.unlock1  = (WDATA == OSD_UNLOCK_KEY1);
            next_s.unlocked = s.unlock1 && (WDATA == OSD_UNLOCK_KEY2);
        end
        else if (WR || RD)
        begin
            next_s.unlock1  = 1'b0;
            next_s.unlocked = s.unlocked && !wr_ctrl;
        end

        if (wr_ctrl)
        begin
            if (!sel_locked)
                next_s.new_source_sel = WDATA[OSD_NEW_LSB +: 3];
            next_s.selection_freeze   = WDATA[OSD_FREEZE_BIT] | s.selection_freeze;
            if (!(PIN_LOCK_ONE_SHOT && s.pin_remap_freeze))
                next_s.pin_remap_freeze = WDATA[OSD_PIN_BIT];
            next_s.clock_fail_flag      = WDATA[OSD_FAIL_BIT];
            next_s.primary_sleep_keep   = WDATA[OSD_PKEEP_BIT];
            next_s.secondary_osc_enable = WDATA[OSD_SEC_BIT];
            if (WDATA[OSD_SW_BIT])
                next_s.switch_request = 1'b1;
        end
        if (fail_s)
            next_s.clock_fail_flag = 1'b1;

        if (wr_div)
        begin
            next_s.recover_on_irq      = WDATA[OSD_ROI_BIT];
            next_s.ratio_sel           = WDATA[OSD_RATIO_LSB +: 3];
            next_s.ratio_reduce_enable = WDATA[OSD_RATEN_BIT];
            next_s.divider_source_sel  = WDATA[OSD_DSRC_LSB +: 3];
            next_s.pll_postscale_sel   = WDATA[OSD_POST_LSB +: 2];
            next_s.pll_force_on        = WDATA[OSD_PLLF_BIT];
        end
        if (WR && ADDR == OSD_TRIM_REGISTER)
            next_s.rc_trim_value = WDATA[5:0];
        // Interrupt wins over a simultaneous write of the enable
        if (irq_s && s.recover_on_irq)
            next_s.ratio_reduce_enable = 1'b0;

        case (s.state)
            OSD_IDLE:
            begin
                next_s.count = 8'h00;
                // Locked or reserved requests simply wait
                if (s.switch_request && !sel_locked
                    && s.new_source_sel != OSD_SRC_RESERVED)
                    next_s.state = OSD_SWITCH;
            end
            OSD_SWITCH:
            begin
                next_s.count = s.count + 8'h01;
                if (s.count == 8'(SWITCH_CYC - 1))
                begin
                    next_s.state              = OSD_IDLE;
                    next_s.current_source_sel = s.new_source_sel;
                    next_s.switch_request     = 1'b0;
                    restart                   = 1'b1;
                end
            end
            default:
                next_s.state = OSD_IDLE;
        endcase

        next_s.primary_run   = !SLEEP || s.primary_sleep_keep;
        next_s.secondary_run = s.secondary_osc_enable;
        next_s.pll_run = s.pll_force_on || (!SLEEP && uses_pll(s.current_source_sel));
        pshift = s.pll_postscale_sel;
        next_s.post_div = 4'(5'h01 << pshift);

        next_s.rdata = 16'h0000;
        if (RD)
        begin
            case (ADDR)
                OSD_OSC_CONTROL_REGISTER:
                    next_s.rdata = {1'b0, s.current_source_sel, 1'b0, s.new_source_sel,
                                    s.selection_freeze, s.pin_remap_freeze,
                                    lock_status & uses_pll(s.current_source_sel), 1'b0,
                                    s.clock_fail_flag, s.primary_sleep_keep,
                                    s.secondary_osc_enable, s.switch_request};
                OSD_CLOCK_DIVIDER_REGISTER:
                    next_s.rdata = {s.recover_on_irq, s.ratio_sel, s.ratio_reduce_enable,
                                    s.divider_source_sel, s.pll_postscale_sel,
                                    s.pll_force_on, 5'h00};
                OSD_TRIM_REGISTER:
                    next_s.rdata = {10'h000, s.rc_trim_value};
                default:
                    next_s.rdata = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            s                   <= '0;
            s.ratio_sel         <= OSD_RATIO_RESET;
            s.pll_postscale_sel <= OSD_POST_RESET;
            s.pll_force_on      <= OSD_PLLF_RESET;
            s.divider_source_sel <= OSD_DSRC_RESET;
            s.post_div          <= 4'h1;
        end
        else
            s <= next_s;
    end

    osd_pll_status #(.START_CYC(START_CYC)) u_pll (
        .clk         (CLK),
        .srst        (SRST),
        .pll_run     (s.pll_run),
        .restart     (restart),
        .pll_locked  (pll_lock_s),
        .lock_status (lock_status)
    );

    osd_ratio_div u_ratio (
        .clk    (CLK),
        .srst   (SRST),
        .enable (s.ratio_reduce_enable),
        .ratio  (s.ratio_sel),
        .tick   (periph_tick)
    );

    assign RDATA            = s.rdata;
    assign ACTIVE_SOURCE    = s.current_source_sel;
    assign PRIMARY_RUN      = s.primary_run;
    assign SECONDARY_RUN    = s.secondary_run;
    assign PLL_RUN          = s.pll_run;
    assign PLL_POST_DIV     = s.post_div;
    assign DIVIDER_SOURCE   = s.divider_source_sel;
    assign RC_TRIM          = s.rc_trim_value;
    assign PIN_REMAP_FREEZE = s.pin_remap_freeze;
    assign PERIPH_TICK      = periph_tick;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_switch_done;
        @(posedge CLK) disable iff (SRST)
        (s.state == OSD_SWITCH && next_s.state == OSD_IDLE) |=>
            !s.switch_request && s.current_source_sel == $past(s.new_source_sel);
    endproperty
    a_switch_done: assert property (p_switch_done) else $error("switch end wrong");

    property p_lock_hold;
        @(posedge CLK) disable iff (SRST)
        (FAILSAFE_CONFIG == 2'b00 && s.selection_freeze && s.state == OSD_IDLE)
            |-> next_s.state == OSD_IDLE;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("switch while frozen");

    property p_reserved_wait;
        @(posedge CLK) disable iff (SRST)
        (s.state == OSD_IDLE && s.new_source_sel == OSD_SRC_RESERVED) |=> s.state == OSD_IDLE;
    endproperty
    a_reserved_wait: assert property (p_reserved_wait) else $error("reserved taken");

    property p_fail_set;
        @(posedge CLK) disable iff (SRST)
        fail_s |=> s.clock_fail_flag;
    endproperty
    a_fail_set: assert property (p_fail_set) else $error("fail flag missed");

    property p_irq_recover;
        @(posedge CLK) disable iff (SRST)
        (irq_s && s.recover_on_irq) |=> !s.ratio_reduce_enable;
    endproperty
    a_irq_recover: assert property (p_irq_recover) else $error("ratio kept on irq");

    property p_pin_oneshot;
        @(posedge CLK) disable iff (SRST)
        (PIN_LOCK_ONE_SHOT && s.pin_remap_freeze) |=> s.pin_remap_freeze;
    endproperty
    a_pin_oneshot: assert property (p_pin_oneshot) else $error("pin freeze cleared");

    property p_request_held;
        @(posedge CLK) disable iff (SRST)
        (s.state == OSD_SWITCH && next_s.state == OSD_SWITCH) |=> s.switch_request;
    endproperty
    a_request_held: assert property (p_request_held) else $error("request dropped");

    property p_post_div;
        @(posedge CLK) disable iff (SRST)
        ##1 PLL_POST_DIV == 4'(5'h01 << $past(s.pll_postscale_sel));
    endproperty
    a_post_div: assert property (p_post_div) else $error("postscale wrong");

    property p_no_lock_on_switch;
        @(posedge CLK) disable iff (SRST)
        restart |-> !lock_status;
    endproperty
    a_no_lock_on_switch: assert property (p_no_lock_on_switch) else $error("lock on switch");

    property p_frozen_keep;
        @(posedge CLK) disable iff (SRST)
        (wr_ctrl && sel_locked) |=> $stable(s.new_source_sel);
    endproperty
    a_frozen_keep: assert property (p_frozen_keep) else $error("frozen source written");

    property p_locked_write;
        @(posedge CLK) disable iff (SRST)
        (WR && ADDR == OSD_OSC_CONTROL_REGISTER && !s.unlocked) |=>
            $stable(s.secondary_osc_enable) && $stable(s.primary_sleep_keep);
    endproperty
    a_locked_write: assert property (p_locked_write) else $error("locked write taken");

    property p_strap;
        @(posedge CLK) disable iff (SRST)
        (!SRST && !s.loaded) |=> s.current_source_sel == $past(RESET_SOURCE_CONFIG);
    endproperty
    a_strap: assert property (p_strap) else $error("strap not loaded");

    property p_sleep_stop;
        @(posedge CLK) disable iff (SRST)
        (SLEEP && !s.primary_sleep_keep) |=> !PRIMARY_RUN;
    endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("primary kept in sleep");

    c_switch: cover property (@(posedge CLK) s.state == OSD_SWITCH ##1 s.state == OSD_IDLE);
    c_fail:   cover property (@(posedge CLK) fail_s);
    c_irq:    cover property (@(posedge CLK) irq_s && s.recover_on_irq && s.ratio_reduce_enable);
    c_reserved: cover property (@(posedge CLK) s.new_source_sel == OSD_SRC_RESERVED);
    c_frozen: cover property (@(posedge CLK) wr_ctrl && sel_locked);

endmodule

// *** osd_top_tb.sv ***
// Self-checking bench for the oscillator select and divider block.
// Assumes osd_pkg and osd_top are compiled first; bench drives all ports.
`timescale 1ns/1ps
module osd_top_tb
    import osd_pkg::*;
;
    logic        CLK, SRST, WR, RD, CLOCK_FAIL, PLL_LOCKED, IRQ, SLEEP, PIN_LOCK_ONE_SHOT;
    logic [11:0] ADDR;
    logic [15:0] WDATA, RDATA;
    logic [2:0]  RESET_SOURCE_CONFIG, ACTIVE_SOURCE, DIVIDER_SOURCE;
    logic [1:0]  FAILSAFE_CONFIG;
    logic [3:0]  PLL_POST_DIV;
    logic [5:0]  RC_TRIM;
    logic        PRIMARY_RUN, SECONDARY_RUN, PLL_RUN, PIN_REMAP_FREEZE, PERIPH_TICK;
    int          mismatches = 0, checks_done = 0, cycles = 0, ticks = 0;
    logic [2:0]  codes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
    logic [2:0]  no_pll [4] = '{3'h0, 3'h2, 3'h4, 3'h5};
    logic [5:0]  trims [4] = '{6'h1f, 6'h20, 6'h00, 6'h3f};

    // ------------------------------------------------------------
    // Design, with the default switch count and a short start-up count
    // ------------------------------------------------------------
    osd_top #(.SWITCH_CYC(8), .START_CYC(8)) dut (
        .CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .RESET_SOURCE_CONFIG(RESET_SOURCE_CONFIG),
        .FAILSAFE_CONFIG(FAILSAFE_CONFIG), .PIN_LOCK_ONE_SHOT(PIN_LOCK_ONE_SHOT),
        .CLOCK_FAIL(CLOCK_FAIL), .PLL_LOCKED(PLL_LOCKED), .IRQ(IRQ), .SLEEP(SLEEP),
        .ACTIVE_SOURCE(ACTIVE_SOURCE), .PRIMARY_RUN(PRIMARY_RUN),
        .SECONDARY_RUN(SECONDARY_RUN), .PLL_RUN(PLL_RUN), .PLL_POST_DIV(PLL_POST_DIV),
        .DIVIDER_SOURCE(DIVIDER_SOURCE), .RC_TRIM(RC_TRIM),
        .PIN_REMAP_FREEZE(PIN_REMAP_FREEZE), .PERIPH_TICK(PERIPH_TICK));

    initial
    begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end

    // Tick counter; a hang ends the run as a failure
    always @(posedge CLK)
    begin
        cycles <= cycles + 1;
        if (PERIPH_TICK === 1'b1)
            ticks <= ticks + 1;
        if (cycles == 30000)
        begin
            mismatches = mismatches + 1;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] ctl(logic [2:0] n, logic fz, pn, k, s, rq);
        return {5'h00, n, fz, pn, 3'h0, k, s, rq};
    endfunction

    function automatic logic [15:0] dv(logic ro, logic [2:0] r, logic en,
                                       logic [2:0] ds, logic [1:0] p, logic f);
        return {ro, r, en, ds, p, f, 5'h00};
    endfunction

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLK);
        WR    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLK);
        RD   <= 1'b0;
        @(posedge CLK);
        d = RDATA;
    endtask

    task automatic uwr(input logic [15:0] d);
        wr(OSD_UNLOCK_REGISTER, OSD_UNLOCK_KEY1);
        wr(OSD_UNLOCK_REGISTER, OSD_UNLOCK_KEY2);
        wr(OSD_OSC_CONTROL_REGISTER, d);
    endtask

    task automatic wait_sw(output logic [15:0] d);
        int n;
        n = 0;
        d = 16'h0001;
        while (d[0] !== 1'b0 && n < 20)
        begin
            rd(OSD_OSC_CONTROL_REGISTER, d);
            n++;
        end
    endtask

    task automatic wrap_up();
        if (mismatches == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [15:0] d;
        logic [2:0]  c, cur, r, ds;
        logic [1:0]  p;
        logic        k, s, en, f;
        int          t0, df, ex;
        void'($urandom(51));
        {SRST, WR, RD, ADDR, WDATA} = {1'b1, 1'b0, 1'b0, 12'h000, 16'h0000};
        {CLOCK_FAIL, PLL_LOCKED, IRQ, SLEEP, FAILSAFE_CONFIG} = 6'h00;
        PIN_LOCK_ONE_SHOT = 1'b1;
        // Non-PLL start source keeps the lock bit out of the reset compare
        RESET_SOURCE_CONFIG = no_pll[$urandom % 4];
        cur = RESET_SOURCE_CONFIG;
        trims[3] = 6'($urandom);
        repeat (5) @(posedge CLK);
        SRST <= 1'b0;
        repeat (2) @(posedge CLK);
        rd(OSD_OSC_CONTROL_REGISTER, d);
        chk("control reset", {1'b0, cur, 1'b0, cur, 8'h00}, d);
        rd(OSD_CLOCK_DIVIDER_REGISTER, d);
        chk("divider reset", 16'h3020, d);
        chk("postscale reset", 16'h0001, 16'(PLL_POST_DIV));
        rd(12'h104, d);
        chk("unmapped read", 16'h0000, d);
        wr(OSD_OSC_CONTROL_REGISTER, ctl(3'h4, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
        repeat (20) @(posedge CLK);
        rd(OSD_OSC_CONTROL_REGISTER, d);
        chk("locked write", {1'b0, cur, 1'b0, cur, 8'h00}, d & 16'h7701);
        foreach (codes[i])
        begin
            c = codes[i];
            k = 1'($urandom);
            s = 1'($urandom);
            uwr(ctl(c, 1'b0, 1'b0, k, s, 1'b1));
            rd(OSD_OSC_CONTROL_REGISTER, d);
            chk("pending", {1'b0, cur, 1'b0, c, 7'h00, 1'b1}, d & 16'h7701);
            wait_sw(d);
            chk("switched", {1'b0, c, 1'b0, c, 8'h00}, d & 16'h7701);
            cur = c;
            repeat (30) @(posedge CLK);
            rd(OSD_OSC_CONTROL_REGISTER, d);
            ex = (c == 3'h1 || c == 3'h3);
            chk("control", {1'b0, c, 1'b0, c, 2'h0, 1'(ex), 2'h0, k, s, 1'b0}, d);
            chk("active source", 16'(c), 16'(ACTIVE_SOURCE));
            chk("secondary run", 16'(s), 16'(SECONDARY_RUN));
            if (c == 3'h2 || c == 3'h3)
            begin
                SLEEP <= 1'b1;
                repeat (3) @(posedge CLK);
                chk("primary in sleep", 16'(k), 16'(PRIMARY_RUN));
                SLEEP <= 1'b0;
            end
        end
        // Reserved code must wait for a rewrite
        uwr(ctl(3'h6, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
        repeat (40) @(posedge CLK);
        rd(OSD_OSC_CONTROL_REGISTER, d);
        chk("reserved", {1'b0, cur, 1'b0, 3'h6, 7'h00, 1'b1}, d & 16'h7701);
        uwr(ctl(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
        wait_sw(d);
        chk("back to fast rc", 16'h0000, d & 16'h7701);
        for (int i = 0; i < 8; i++)
        begin
            r  = 3'(i);
            en = (i != 2);
            ds = (i == 0) ? 3'h5 : 3'($urandom % 6);
            p  = 2'($urandom);
            f  = 1'($urandom);
            wr(OSD_CLOCK_DIVIDER_REGISTER, dv(1'b0, r, en, ds, p, f));
            rd(OSD_CLOCK_DIVIDER_REGISTER, d);
            chk("divider", dv(1'b0, r, en, ds, p, f), d);
            chk("postscale", 16'(4'h1 << p), 16'(PLL_POST_DIV));
            chk("divider source", 16'(ds), 16'(DIVIDER_SOURCE));
            chk("pll run", 16'(f), 16'(PLL_RUN));
            t0 = ticks;
            repeat (256) @(posedge CLK);
            df = ticks - t0;
            ex = en ? (256 >> i) : 256;
            // Phase of the first tick is free, so one tick either way
            if (df == ex + 1 || df == ex - 1)
                df = ex;
            chk("tick count", 16'(ex), 16'(df));
        end
        for (int j = 0; j < 2; j++)
        begin
            wr(OSD_CLOCK_DIVIDER_REGISTER, dv(1'(j), 3'h2, 1'b1, 3'h0, 2'h0, 1'b1));
            IRQ <= 1'b1;
            repeat (4) @(posedge CLK);
            IRQ <= 1'b0;
            repeat (4) @(posedge CLK);
            rd(OSD_CLOCK_DIVIDER_REGISTER, d);
            chk("ratio enable", {4'h0, ~1'(j), 11'h000}, d & 16'h0800);
        end
        foreach (trims[i])
        begin
            wr(OSD_TRIM_REGISTER, {10'h000, trims[i]});
            rd(OSD_TRIM_REGISTER, d);
            chk("trim", {10'h000, trims[i]}, d & 16'h003f);
            chk("trim out", {10'h000, trims[i]}, {10'h000, RC_TRIM});
        end
        CLOCK_FAIL <= 1'b1;
        repeat (6) @(posedge CLK);
        rd(OSD_OSC_CONTROL_REGISTER, d);
        chk("clock fail", 16'h0008, d & 16'h0008);
        uwr(ctl(3'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
        repeat (2) @(posedge CLK);
        chk("pin freeze", 16'h0001, 16'(PIN_REMAP_FREEZE));
        uwr(ctl(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
        repeat (2) @(posedge CLK);
        chk("pin freeze kept", 16'h0001, 16'(PIN_REMAP_FREEZE));
        uwr(ctl(3'h0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0));
        uwr(ctl(3'h2, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1));
        repeat (30) @(posedge CLK);
        rd(OSD_OSC_CONTROL_REGISTER, d);
        chk("frozen", 16'h0000, d & 16'h7700);
        FAILSAFE_CONFIG <= 2'b10;
        uwr(ctl(3'h2, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1));
        wait_sw(d);
        chk("unfrozen", 16'h2200, d & 16'h7701);
        wrap_up();
    end
endmodule
